// ==== common/port_c_pin_map.svh ====
`ifndef PORT_C_PIN_MAP_SVH
`define PORT_C_PIN_MAP_SVH
`define SEL_ANALOG 3'h0
`define SEL_GPIO 3'h1
`define SEL_PWM 3'h2
`define SEL_TEST 3'h3
`define SEL_SS 3'h4
`define SEL_TIMER 3'h5
`define SEL_CMPOUT 3'h6
`define TAP_IR_LEN 4
`define TAP_IR_RESET 4'h1
`define TAP_IR_BYPASS 4'hf
`define PULL_RESET 5'h18
`define PAD_SYNC_IDLE 5'h1f
`define TMS_SYNC_IDLE 2'h3
`endif

// ==== common/port_c_pin_pkg.sv ====
package port_c_pin_pkg;
   typedef enum logic [3:0] {
      TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
      TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR,
      TAP_SHIFT_IR, TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
   } tap_state_t;
endpackage

// ==== design/test_port.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "port_c_pin_map.svh"
module test_port
   import port_c_pin_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // Synchronised test pins
   input wire logic tckRise,
   input wire logic tckFall,
   input wire logic tmsIn,
   input wire logic tdiIn,
   // Test data out
   output logic tdoOut,
   output logic tdoOe
);
   tap_state_t state_r, state_nxt;
   logic [`TAP_IR_LEN-1:0] irShift_r, irShift_nxt;
   logic bypass_r, bypass_nxt, tdo_r, tdo_nxt, oe_r, oe_nxt;

   // ----------------------------------------
   // Controller
   // ----------------------------------------
   always_comb
   begin
      state_nxt = state_r;
      irShift_nxt = irShift_r;
      bypass_nxt = bypass_r;
      tdo_nxt = tdo_r;
      oe_nxt = oe_r;
      if (tckRise)
      begin
         case (state_r)
            TAP_RESET: state_nxt = tmsIn ? TAP_RESET : TAP_IDLE;
            TAP_IDLE: state_nxt = tmsIn ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_DR: state_nxt = tmsIn ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR:
            begin
               bypass_nxt = 1'b0;
               state_nxt = tmsIn ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            end
            TAP_SHIFT_DR:
            begin
               bypass_nxt = tdiIn;
               state_nxt = tmsIn ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            end
            TAP_EXIT1_DR: state_nxt = tmsIn ? TAP_UPD_DR : TAP_PAUSE_DR;
            TAP_PAUSE_DR: state_nxt = tmsIn ? TAP_EXIT2_DR : TAP_PAUSE_DR;
            TAP_EXIT2_DR: state_nxt = tmsIn ? TAP_UPD_DR : TAP_SHIFT_DR;
            TAP_UPD_DR: state_nxt = tmsIn ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_IR: state_nxt = tmsIn ? TAP_RESET : TAP_CAP_IR;
            TAP_CAP_IR:
            begin
               irShift_nxt = `TAP_IR_RESET;
               state_nxt = tmsIn ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            end
            TAP_SHIFT_IR:
            begin
               irShift_nxt = {tdiIn, irShift_r[`TAP_IR_LEN-1:1]};
               state_nxt = tmsIn ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            end
            TAP_EXIT1_IR: state_nxt = tmsIn ? TAP_UPD_IR : TAP_PAUSE_IR;
            TAP_PAUSE_IR: state_nxt = tmsIn ? TAP_EXIT2_IR : TAP_PAUSE_IR;
            TAP_EXIT2_IR: state_nxt = tmsIn ? TAP_UPD_IR : TAP_SHIFT_IR;
            // Only bypass exists, so the shifted instruction is not kept
            TAP_UPD_IR: state_nxt = tmsIn ? TAP_SEL_DR : TAP_IDLE;
            default: state_nxt = TAP_RESET;
         endcase
      end
      // Output moves on the falling edge so the tester samples a settled bit
      if (tckFall)
      begin
         oe_nxt = (state_r == TAP_SHIFT_IR) || (state_r == TAP_SHIFT_DR);
         tdo_nxt = (state_r == TAP_SHIFT_IR) ? irShift_r[0] : bypass_r;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         state_r <= TAP_RESET;
         irShift_r <= `TAP_IR_RESET;
         bypass_r <= 1'b0;
         tdo_r <= 1'b0;
         oe_r <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         irShift_r <= irShift_nxt;
         bypass_r <= bypass_nxt;
         tdo_r <= tdo_nxt;
         oe_r <= oe_nxt;
      end
   end

   assign tdoOut = tdo_r;
   assign tdoOe = oe_r;
endmodule
`default_nettype wire

// ==== design/port_c_and_test_pin_mux.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "port_c_pin_map.svh"
module port_c_and_test_pin_mux
   import port_c_pin_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // Function selects, one per pin
   input wire logic [2:0] selC4,
   input wire logic [2:0] selC5,
   input wire logic [2:0] selC6,
   input wire logic [2:0] selC7,
   input wire logic [2:0] selTdi,
   input wire logic selApply,
   // GPIO side, bits 0..3 are port C 4..7, bit 4 is port D 0
   input wire logic [4:0] gpioOut,
   input wire logic [4:0] gpioDirOut,
   output logic [4:0] gpioIn,
   // Peripheral side
   input wire logic pulseWidthOutCh2,
   input wire logic comparator1ResultOut,
   output logic spiSlaveSelectN,
   output logic dualTimerInputCh2,
   output logic [4:0] analogConnect,
   // Pins: C4, C5, C6, C7, TDI
   input wire logic [4:0] padIn,
   output logic [4:0] padOut,
   output logic [4:0] padOe,
   output logic [4:0] padPullup,
   // Test pins
   input wire logic tckPin,
   input wire logic tmsPin,
   output logic tdoPin,
   output logic tdoOe,
   output logic tdoPullup
);
   logic [2:0] sel_r [5];
   logic [2:0] sel_nxt [5];
   logic [4:0] padS1_r, padS2_r, padOut_r, padOut_nxt, padOe_r, padOe_nxt;
   logic [4:0] pull_r, pull_nxt;
   logic [2:0] tckS_r, tckS_nxt;
   logic [1:0] tmsS_r, tmsS_nxt;
   logic tdoOeInt;

   // Default function of each pin out of reset
   function automatic logic [2:0] resetSel(input int idx);
      case (idx)
         0: resetSel = `SEL_ANALOG;
         1: resetSel = `SEL_ANALOG;
         2: resetSel = `SEL_ANALOG;
         3: resetSel = `SEL_GPIO;
         default: resetSel = `SEL_TEST;
      endcase
   endfunction

   // Which selects are legal on which pin; illegal ones are ignored
   function automatic logic legalSel(input int idx, input logic [2:0] s);
      case (idx)
         0, 1, 3: legalSel = (s == `SEL_ANALOG) || (s == `SEL_GPIO);
         2: legalSel = (s == `SEL_ANALOG) || (s == `SEL_GPIO) || (s == `SEL_PWM);
         default: legalSel = (s <= `SEL_CMPOUT) && (s != `SEL_PWM);
      endcase
   endfunction

   // ----------------------------------------
   // Function select and pad drive
   // ----------------------------------------
   always_comb
   begin
      logic [2:0] req [5];
      req[0] = selC4;
      req[1] = selC5;
      req[2] = selC6;
      req[3] = selC7;
      req[4] = selTdi;
      padOut_nxt = '0;
      padOe_nxt = '0;
      pull_nxt = '0;
      for (int i = 0; i < 5; i++)
      begin
         sel_nxt[i] = sel_r[i];
         if (selApply && legalSel(i, req[i]))
            sel_nxt[i] = req[i];
         // One driver per pin; analog leaves the output off
         case (sel_nxt[i])
            `SEL_GPIO:
            begin
               padOut_nxt[i] = gpioOut[i];
               padOe_nxt[i] = gpioDirOut[i];
               pull_nxt[i] = !gpioDirOut[i];
            end
            `SEL_PWM:
            begin
               padOut_nxt[i] = pulseWidthOutCh2;
               padOe_nxt[i] = 1'b1;
            end
            `SEL_CMPOUT:
            begin
               padOut_nxt[i] = comparator1ResultOut;
               padOe_nxt[i] = 1'b1;
            end
            `SEL_TEST, `SEL_SS, `SEL_TIMER: pull_nxt[i] = 1'b1;
            default: pull_nxt[i] = 1'b0;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         for (int i = 0; i < 5; i++)
            sel_r[i] <= resetSel(i);
         padOut_r <= '0;
         padOe_r <= '0;
         pull_r <= `PULL_RESET;
      end
      else
      begin
         for (int i = 0; i < 5; i++)
            sel_r[i] <= sel_nxt[i];
         padOut_r <= padOut_nxt;
         padOe_r <= padOe_nxt;
         pull_r <= pull_nxt;
      end
   end

   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   always_comb
   begin
      tckS_nxt = {tckS_r[1:0], tckPin};
      tmsS_nxt = {tmsS_r[0], tmsPin};
   end

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         padS1_r <= `PAD_SYNC_IDLE;
         padS2_r <= `PAD_SYNC_IDLE;
         tckS_r <= '0;
         tmsS_r <= `TMS_SYNC_IDLE;
      end
      else
      begin
         padS1_r <= padIn;
         padS2_r <= padS1_r;
         tckS_r <= tckS_nxt;
         tmsS_r <= tmsS_nxt;
      end
   end

   // ----------------------------------------
   // Outputs to peripherals
   // ----------------------------------------
   always_comb
   begin
      for (int i = 0; i < 5; i++)
      begin
         gpioIn[i] = (sel_r[i] == `SEL_GPIO) ? padS2_r[i] : 1'b0;
         analogConnect[i] = (sel_r[i] == `SEL_ANALOG);
      end
      // Slave select idles high when the pin is elsewhere
      spiSlaveSelectN = (sel_r[4] == `SEL_SS) ? padS2_r[4] : 1'b1;
      dualTimerInputCh2 = (sel_r[4] == `SEL_TIMER) ? padS2_r[4] : 1'b0;
   end

   assign padOut = padOut_r;
   assign padOe = padOe_r;
   assign padPullup = pull_r;

   // Edges found on the sampled gated clock; no edge expected outside a scan
   test_port u_tap (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .tckRise(tckS_r[1] && !tckS_r[2] && (sel_r[4] == `SEL_TEST)),
      .tckFall(!tckS_r[1] && tckS_r[2]),
      .tmsIn(tmsS_r[1]),
      .tdiIn(padS2_r[4]),
      .tdoOut(tdoPin),
      .tdoOe(tdoOeInt)
   );

   assign tdoOe = tdoOeInt;
   assign tdoPullup = !tdoOeInt;
endmodule
`default_nettype wire

// ==== sim/port_c_and_test_pin_mux_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module pin_mux_checker
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // Watched ports
   input wire logic [4:0] gpioOut,
   input wire logic [4:0] gpioDirOut,
   input wire logic [4:0] gpioIn,
   input wire logic [4:0] analogConnect,
   input wire logic [4:0] padOut,
   input wire logic [4:0] padOe,
   input wire logic [4:0] padPullup,
   input wire logic spiSlaveSelectN,
   input wire logic dualTimerInputCh2,
   input wire logic tckPin,
   input wire logic tdoPin,
   input wire logic tdoOe,
   input wire logic tdoPullup
);
   // ---------------
   // Pin properties
   // ---------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   // C4, C5, C7 accept only analog or GPIO, so not analog means GPIO
   reset_defaults_a:
      assert property ($rose(rstn) |-> padOe == 5'h00 && padPullup == 5'h18 &&
         analogConnect == 5'h07) else $error("reset defaults wrong");
   tdo_pull_a:
      assert property (tdoPullup == !tdoOe) else $error("tdo pullup wrong");
   tdo_fall_a:
      assert property ($changed(tdoPin) || $changed(tdoOe) |-> $past(tckPin, 2) == 1'b0)
         else $error("tdo moved off a falling edge");
   analog_quiet_a:
      assert property ((analogConnect & (padOe | padPullup | gpioIn)) == 5'h00)
         else $error("analog pin still digital");
   gpio_dir_a:
      assert property (((padOe ^ $past(gpioDirOut)) & ~analogConnect &
         ~$past(analogConnect) & 5'h0b) == 5'h00) else $error("gpio dir wrong");
   gpio_out_a:
      assert property (((padOut ^ $past(gpioOut)) & padOe & ~$past(analogConnect) &
         5'h0b) == 5'h00) else $error("gpio data wrong");
   gpio_pull_a:
      assert property ((~analogConnect & ~padOe & ~padPullup & 5'h0b) == 5'h00)
         else $error("gpio input pullup off");
   tdi_quiet_a:
      assert property (analogConnect[4] && $past(analogConnect[4]) |->
         spiSlaveSelectN && !dualTimerInputCh2) else $error("tdi alternate leaks");
   cover property ($rose(tdoOe));
   cover property ($rose(padOe[2]));
   cover property ($fell(spiSlaveSelectN));
endmodule
bind port_c_and_test_pin_mux pin_mux_checker i_chk (.sys_clk, .rstn, .gpioOut,
   .gpioDirOut, .gpioIn, .analogConnect, .padOut, .padOe, .padPullup, .spiSlaveSelectN,
   .dualTimerInputCh2, .tckPin, .tdoPin, .tdoOe, .tdoPullup);
`default_nettype wire

// ==== sim/tap_tester.sv ====
`timescale 1ns/1ps
`default_nettype none
module tap_tester
(
   // Clock
   input wire logic sys_clk,
   // Test pins
   output logic tckPin,
   output logic tmsPin,
   output logic tdiPin,
   input wire logic tdoPin,
   input wire logic tdoOe
);
   // ---------------
   // Tester model
   // ---------------
   logic tdoLine;
   // Released line floats up
   assign tdoLine = tdoOe ? tdoPin : 1'b1;
   initial
   begin
      tckPin = 1'b0;
      tmsPin = 1'b1;
      tdiPin = 1'b1;
   end
   // Slave select and timer input share the data line
   task automatic setTdi(input logic v);
      tdiPin = v;
   endtask
   // Gated clock, low between pulses, 200 ns period
   task automatic pulse(input logic tms, input logic tdi, output logic tdo);
      @(negedge sys_clk);
      tmsPin = tms;
      tdiPin = tdi;
      repeat (3) @(negedge sys_clk);
      tckPin = 1'b1;
      tdo = tdoLine;
      repeat (4) @(negedge sys_clk);
      tckPin = 1'b0;
   endtask
endmodule
`default_nettype wire

// ==== sim/port_c_and_test_pin_mux_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module port_c_and_test_pin_mux_bench;
   // ---------------
   // Bench
   // ---------------
   logic sys_clk, rstn, selApply, pwm, cmpOut, ssN, tmr, tckPin, tmsPin, tdiPin;
   logic tdoPin, tdoOe, tdoPullup;
   logic [2:0] selC4, selC5, selC6, selC7, selTdi;
   logic [4:0] gpioOut, gpioDirOut, gpioIn, analogConnect, padIn, padOut, padOe, padPullup;
   logic [3:0] padExt;
   logic [15:0] got;
   int errTotal = 0;
   int totalChecks = 0;
   assign padIn = (padOe & padOut) | (~padOe & {tdiPin, padExt});
   port_c_and_test_pin_mux i_dut (.sys_clk, .rstn, .selC4, .selC5, .selC6, .selC7,
      .selTdi, .selApply, .gpioOut, .gpioDirOut, .gpioIn, .pulseWidthOutCh2(pwm),
      .comparator1ResultOut(cmpOut), .spiSlaveSelectN(ssN), .dualTimerInputCh2(tmr),
      .analogConnect, .padIn, .padOut, .padOe, .padPullup, .tckPin, .tmsPin, .tdoPin,
      .tdoOe, .tdoPullup);
   tap_tester i_tst (.sys_clk, .tckPin, .tmsPin, .tdiPin, .tdoPin, .tdoOe);
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      totalChecks++;
      if (seen !== exp)
      begin
         errTotal++;
         $display("unexpected at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic stopTest;
      if (errTotal == 0 && totalChecks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic apply(input logic [14:0] s);
      @(negedge sys_clk);
      {selC4, selC5, selC6, selC7, selTdi} = s;
      selApply = 1'b1;
      @(negedge sys_clk);
      selApply = 1'b0;
      repeat (4) @(negedge sys_clk);
   endtask
   task automatic scan(input logic [15:0] tms, input logic [15:0] tdi, input int n);
      logic b;
      got = 16'h0;
      for (int i = 0; i < n; i++)
      begin
         i_tst.pulse(tms[i], tdi[i], b);
         got[i] = b;
      end
   endtask
   task automatic t_reset;
      chk(16'(padOe), 16'h00);
      chk(16'(padPullup), 16'h18);
      chk(16'(analogConnect), 16'h07);
      chk(16'({tdoOe, tdoPullup}), 16'h1);
   endtask
   task automatic t_gpio;
      {gpioDirOut, gpioOut, padExt} = {5'h05, 5'h1f, 4'h8};
      apply({3'h1, 3'h1, 3'h1, 3'h1, 3'h3});
      chk(16'(padOe & padOut), 16'h05);
      chk(16'({padPullup, gpioIn}), 16'h34d);
      gpioDirOut = 5'h0a;
      repeat (4) @(negedge sys_clk);
      chk(16'({padOe, padPullup, gpioIn}), 16'h2aaa);
   endtask
   task automatic t_pwm;
      {gpioDirOut, pwm} = {5'h00, 1'b1};
      apply({3'h2, 3'h1, 3'h2, 3'h1, 3'h3});
      chk(16'({analogConnect, padOe, padOut[2]}), 16'h09);
      pwm = 1'b0;
      repeat (2) @(negedge sys_clk);
      chk(16'(padOut[2]), 16'h0);
   endtask
   task automatic t_tdi;
      apply({3'h1, 3'h1, 3'h2, 3'h1, 3'h4});
      i_tst.setTdi(1'b0);
      repeat (4) @(negedge sys_clk);
      chk(16'(ssN), 16'h0);
      i_tst.setTdi(1'b1);
      apply({3'h1, 3'h1, 3'h2, 3'h1, 3'h5});
      chk(16'({tmr, ssN}), 16'h3);
      cmpOut = 1'b1;
      apply({3'h1, 3'h1, 3'h2, 3'h1, 3'h6});
      apply({3'h1, 3'h1, 3'h2, 3'h1, 3'h2});
      chk(16'({padOe[4], padOut[4]}), 16'h3);
      {gpioDirOut, gpioOut} = {5'h10, 5'h0f};
      apply({3'h1, 3'h1, 3'h2, 3'h1, 3'h1});
      chk(16'({padOe[4], padOut[4], gpioIn[4], padPullup[4]}), 16'h8);
      gpioDirOut = 5'h00;
      apply({3'h1, 3'h1, 3'h6, 3'h0, 3'h0});
      chk(16'({analogConnect, padOe}), 16'h304);
      apply({3'h0, 3'h0, 3'h0, 3'h1, 3'h3});
   endtask
   task automatic t_tap;
      scan(16'h20df, 16'hffff, 14);
      chk(got, 16'h07ff);
      repeat (4) @(negedge sys_clk);
      chk(16'(tdoOe), 16'h0);
      scan(16'h00c3, 16'h0050, 9);
      chk(got, 16'h01af);
   endtask
   initial
   begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   initial
   begin
      #60000;
      errTotal++;
      stopTest();
   end
   initial
   begin
      {rstn, selApply, pwm, cmpOut, gpioOut, gpioDirOut, padExt} = '0;
      {selC4, selC5, selC6, selC7, selTdi} = {3'h0, 3'h0, 3'h0, 3'h1, 3'h3};
      repeat (4) @(negedge sys_clk);
      rstn = 1'b1;
      @(negedge sys_clk);
      t_reset();
      t_gpio();
      t_pwm();
      t_tdi();
      t_tap();
      stopTest();
   end
endmodule
`default_nettype wire
